// ==== rtl/led_channel_source_map_and_engine_instr.v ====
// Functional notes
// RL1: drive code is 8 bits, 0.1 mA steps
// RL2: white drive code resets to AFh
// RL3: source map at 70h resets to 39h
// RL4: map bits 7:6 pick white source
// RL5: map bits 5:4 pick red source
// RL6: map bits 3:2 pick green source
// RL7: map bits 1:0 pick blue source
// RL8: program memory 10h-6Fh resets to zero
// RL9: decode goto-start, set-pwm and ramp/wait words
// RL10: trigger waits on all selected channels
// RL11: trigger sends on each selected channel
// RL12: host configures controller after every power-up
// RL13: multiple controllers share one external clock
// RL14: two pins pick one of four addresses
// RL15: config bit 6 clear gives 256 Hz
// RL16: clock field 00 selects external clock
// RL17: config bit 5 enables power save
// RL18: drive registers at 05h,06h,07h,0Fh
// RL19: clock field 01/11 internal, 10 automatic
// RL20: config bit 6 set gives 558 Hz
// RL21: decode branch and end instruction words
`timescale 1ns/1ps
`include "led_ctrl_defs.vh"
module led_channel_source_map_and_engine_instr #(
   parameter [4:0] BUS_ADDR_BASE = 5'b0110_0
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // serial register bus, open drain data
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n,
   // address straps
   input wire bus_addr_pin0,
   input wire bus_addr_pin1,
   // engine pwm levels
   input wire [7:0] eng1_pwm,
   input wire [7:0] eng2_pwm,
   input wire [7:0] eng3_pwm,
   // per-output pwm duty after source selection
   output reg [7:0] white_pwm,
   output reg [7:0] red_pwm,
   output reg [7:0] green_pwm,
   output reg [7:0] blue_pwm,
   // drive-current codes
   output reg [7:0] white_drive,
   output reg [7:0] red_drive,
   output reg [7:0] green_drive,
   output reg [7:0] blue_drive,
   // configuration
   output reg pwm_freq_select,
   output reg power_save_enable,
   output reg clock_use_external,
   output reg clock_use_internal,
   output reg clock_auto_detect,
   // instruction decode request
   input wire dec_req,
   input wire [1:0] dec_engine,
   input wire [3:0] dec_step,
   // decoded instruction
   output reg dec_valid,
   output reg op_goto_start,
   output reg op_set_pwm,
   output reg op_ramp_wait,
   output reg op_branch,
   output reg op_end,
   output reg op_trigger,
   output reg ramp_prescale,
   output reg [5:0] ramp_step_time,
   output reg ramp_sign,
   output reg [6:0] ramp_increment,
   output reg [7:0] set_pwm_value,
   output reg [5:0] branch_loop_count,
   output reg [3:0] branch_target_step,
   output reg end_int,
   output reg end_reset,
   // trigger channels
   input wire [5:0] trig_in,
   output reg [5:0] trig_out,
   output reg trig_stall
);
   // ****************************************
   // bus state machine
   // ****************************************
   localparam [6:0] S_IDLE = 7'b000_0001;
   localparam [6:0] S_ADDR = 7'b000_0010;
   localparam [6:0] S_AACK = 7'b000_0100;
   localparam [6:0] S_RX = 7'b000_1000;
   localparam [6:0] S_WACK = 7'b001_0000;
   localparam [6:0] S_TX = 7'b010_0000;
   localparam [6:0] S_MACK = 7'b100_0000;

   reg [7:0] mem_r [0:`MEM_BYTES-1];
   reg [7:0] blue_pwm_r, green_pwm_r, red_pwm_r, white_pwm_r;
   reg [7:0] blue_drv_r, green_drv_r, red_drv_r, white_drv_r;
   reg [7:0] config_r, map_r;
   reg scl_s, sda_s, scl_p, sda_p;
   reg [6:0] st_r;
   reg [3:0] cnt_r;
   reg [7:0] shift_r, ptr_r;
   reg rw_r, first_r;
   reg [5:0] wait_mask_r, pend_r;
   reg [15:0] word;
   reg [5:0] pend_nxt;
   integer i;

   wire [6:0] my_addr = {BUS_ADDR_BASE, bus_addr_pin1, bus_addr_pin0}; // [RL14]
   wire start_c = scl_s & scl_p & sda_p & ~sda_s;
   wire stop_c = scl_s & scl_p & ~sda_p & sda_s;
   wire rise = scl_s & ~scl_p;
   wire fall = ~scl_s & scl_p;
   wire wr_en = (st_r == S_RX) & fall & (cnt_r == 4'd8) & ~first_r;
   wire soft_rst = wr_en & (ptr_r == `OFS_SOFT_RESET) & (shift_r == `SOFT_RESET_KEY);
   wire reg_rst = ~rstn | soft_rst;
   wire [7:0] mem_idx = ptr_r - `OFS_MEM_FIRST;
   wire in_mem = (ptr_r >= `OFS_MEM_FIRST) && (ptr_r <= `OFS_MEM_LAST);

   function [7:0] pick;
      input [1:0] sel;
      input [7:0] direct, e1, e2, e3;
      begin
         case (sel)
            2'b00: pick = direct;
            2'b01: pick = e1;
            2'b10: pick = e2;
            default: pick = e3;
         endcase
      end
   endfunction

   function [7:0] rdata;
      input [7:0] a;
      begin
         case (a)
            `OFS_BLUE_PWM: rdata = blue_pwm_r;
            `OFS_GREEN_PWM: rdata = green_pwm_r;
            `OFS_RED_PWM: rdata = red_pwm_r;
            `OFS_WHITE_PWM: rdata = white_pwm_r;
            `OFS_BLUE_DRIVE: rdata = blue_drv_r;
            `OFS_GREEN_DRIVE: rdata = green_drv_r;
            `OFS_RED_DRIVE: rdata = red_drv_r;
            `OFS_WHITE_DRIVE: rdata = white_drv_r;
            `OFS_CONFIG: rdata = config_r;
            `OFS_SOURCE_MAP: rdata = map_r;
            default: rdata = in_mem ? mem_r[mem_idx[6:0]] : 8'h00;
         endcase
      end
   endfunction

   // ****************************************
   // serial slave
   // ****************************************
   always @(posedge clk) begin
      if (!rstn) begin
         scl_s <= 1'b1;
         sda_s <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
         st_r <= S_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         first_r <= 1'b0;
         sda_oe_n <= 1'b1;
         sda_out <= 1'b0;
      end else begin
         scl_s <= scl_in;
         sda_s <= sda_in;
         scl_p <= scl_s;
         sda_p <= sda_s;
         sda_out <= 1'b0;
         if (start_c) begin
            st_r <= S_ADDR;
            cnt_r <= 4'h0;
            sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            st_r <= S_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (st_r)
               S_ADDR: begin
                  if (rise) begin
                     shift_r <= {shift_r[6:0], sda_s};
                     cnt_r <= cnt_r + 4'd1;
                  end else if (fall && cnt_r == 4'd8) begin
                     if (shift_r[7:1] == my_addr) begin // [RL14]
                        st_r <= S_AACK;
                        rw_r <= shift_r[0];
                        sda_oe_n <= 1'b0;
                     end else begin
                        st_r <= S_IDLE;
                     end
                  end
               end
               S_AACK: begin
                  if (fall) begin
                     cnt_r <= 4'h0;
                     if (rw_r) begin
                        st_r <= S_TX;
                        shift_r <= rdata(ptr_r);
                        sda_oe_n <= (rdata(ptr_r) >= 8'h80);
                     end else begin
                        st_r <= S_RX;
                        first_r <= 1'b1;
                        sda_oe_n <= 1'b1;
                     end
                  end
               end
               S_RX: begin
                  if (rise) begin
                     shift_r <= {shift_r[6:0], sda_s};
                     cnt_r <= cnt_r + 4'd1;
                  end else if (fall && cnt_r == 4'd8) begin
                     st_r <= S_WACK;
                     sda_oe_n <= 1'b0;
                     first_r <= 1'b0;
                     // the first byte after the address sets the pointer
                     ptr_r <= first_r ? shift_r : ptr_r + 8'd1;
                  end
               end
               S_WACK: begin
                  if (fall) begin
                     st_r <= S_RX;
                     cnt_r <= 4'h0;
                     sda_oe_n <= 1'b1;
                  end
               end
               S_TX: begin
                  if (rise) begin
                     cnt_r <= cnt_r + 4'd1;
                  end else if (fall) begin
                     if (cnt_r == 4'd8) begin
                        st_r <= S_MACK;
                        sda_oe_n <= 1'b1;
                        ptr_r <= ptr_r + 8'd1;
                     end else begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_oe_n <= shift_r[6];
                     end
                  end
               end
               S_MACK: begin
                  // a high level on the ack clock means the master is done
                  if (rise && sda_s) begin
                     st_r <= S_IDLE;
                  end else if (fall) begin
                     st_r <= S_TX;
                     cnt_r <= 4'h0;
                     shift_r <= rdata(ptr_r);
                     sda_oe_n <= (rdata(ptr_r) >= 8'h80);
                  end
               end
               S_IDLE: st_r <= S_IDLE;
               default: st_r <= S_IDLE;
            endcase
         end
      end
   end

   // ****************************************
   // register file
   // ****************************************
   always @(posedge clk) begin
      if (reg_rst) begin
         blue_pwm_r <= `RST_PWM;
         green_pwm_r <= `RST_PWM;
         red_pwm_r <= `RST_PWM;
         white_pwm_r <= `RST_PWM;
         blue_drv_r <= `RST_DRIVE;
         green_drv_r <= `RST_DRIVE;
         red_drv_r <= `RST_DRIVE;
         white_drv_r <= `RST_DRIVE; // [RL2]
         config_r <= `RST_CONFIG;
         map_r <= `RST_SOURCE_MAP; // [RL3]
         for (i = 0; i < `MEM_BYTES; i = i + 1) begin
            mem_r[i] <= `RST_MEM; // [RL8]
         end
      end else if (wr_en) begin
         case (ptr_r)
            `OFS_BLUE_PWM: blue_pwm_r <= shift_r;
            `OFS_GREEN_PWM: green_pwm_r <= shift_r;
            `OFS_RED_PWM: red_pwm_r <= shift_r;
            `OFS_WHITE_PWM: white_pwm_r <= shift_r;
            `OFS_BLUE_DRIVE: blue_drv_r <= shift_r; // [RL18]
            `OFS_GREEN_DRIVE: green_drv_r <= shift_r; // [RL18]
            `OFS_RED_DRIVE: red_drv_r <= shift_r; // [RL18]
            `OFS_WHITE_DRIVE: white_drv_r <= shift_r; // [RL18] [RL1]
            `OFS_CONFIG: config_r <= shift_r;
            `OFS_SOURCE_MAP: map_r <= shift_r; // [RL3]
            default: begin
               if (in_mem) begin
                  mem_r[mem_idx[6:0]] <= shift_r; // [RL8]
               end
            end
         endcase
      end
   end

   // ****************************************
   // outputs: source mapping and configuration
   // ****************************************
   always @(posedge clk) begin
      if (!rstn) begin
         white_pwm <= 8'h00;
         red_pwm <= 8'h00;
         green_pwm <= 8'h00;
         blue_pwm <= 8'h00;
         white_drive <= `RST_DRIVE;
         red_drive <= `RST_DRIVE;
         green_drive <= `RST_DRIVE;
         blue_drive <= `RST_DRIVE;
         pwm_freq_select <= 1'b0;
         power_save_enable <= 1'b0;
         clock_use_external <= 1'b1;
         clock_use_internal <= 1'b0;
         clock_auto_detect <= 1'b0;
      end else begin
         white_pwm <= pick(map_r[`MAP_WHITE_HI:`MAP_WHITE_LO], white_pwm_r,
            eng1_pwm, eng2_pwm, eng3_pwm); // [RL4]
         red_pwm <= pick(map_r[`MAP_RED_HI:`MAP_RED_LO], red_pwm_r,
            eng1_pwm, eng2_pwm, eng3_pwm); // [RL5]
         green_pwm <= pick(map_r[`MAP_GREEN_HI:`MAP_GREEN_LO], green_pwm_r,
            eng1_pwm, eng2_pwm, eng3_pwm); // [RL6]
         blue_pwm <= pick(map_r[`MAP_BLUE_HI:`MAP_BLUE_LO], blue_pwm_r,
            eng1_pwm, eng2_pwm, eng3_pwm); // [RL7]
         white_drive <= white_drv_r; // [RL1]
         red_drive <= red_drv_r;
         green_drive <= green_drv_r;
         blue_drive <= blue_drv_r;
         // 0 gives 256 Hz, 1 gives 558 Hz
         pwm_freq_select <= config_r[`CFG_PWM_FREQ_BIT]; // [RL15] [RL20]
         power_save_enable <= config_r[`CFG_PWR_SAVE_BIT]; // [RL17]
         clock_use_external <= ~config_r[`CFG_CLK_DET_BIT] &
            ~config_r[`CFG_INT_CLK_BIT]; // [RL16]
         clock_use_internal <= config_r[`CFG_INT_CLK_BIT]; // [RL19]
         clock_auto_detect <= config_r[`CFG_CLK_DET_BIT] &
            ~config_r[`CFG_INT_CLK_BIT]; // [RL19]
      end
   end

   // ****************************************
   // instruction decode
   // ****************************************
   // each engine owns a 32-byte section, high byte of a word first
   wire [6:0] dec_base = {dec_engine - 2'd1, dec_step, 1'b0};

   always @* begin
      word = {mem_r[dec_base], mem_r[dec_base + 7'd1]};
   end

   always @(posedge clk) begin
      if (!rstn) begin
         dec_valid <= 1'b0;
         op_goto_start <= 1'b0;
         op_set_pwm <= 1'b0;
         op_ramp_wait <= 1'b0;
         op_branch <= 1'b0;
         op_end <= 1'b0;
         op_trigger <= 1'b0;
         ramp_prescale <= 1'b0;
         ramp_step_time <= 6'h00;
         ramp_sign <= 1'b0;
         ramp_increment <= 7'h00;
         set_pwm_value <= 8'h00;
         branch_loop_count <= 6'h00;
         branch_target_step <= 4'h0;
         end_int <= 1'b0;
         end_reset <= 1'b0;
      end else begin
         // engine code 0 names no engine and yields no decode
         dec_valid <= dec_req & (dec_engine != 2'b00);
         if (dec_req && dec_engine != 2'b00) begin
            op_goto_start <= (word == 16'h0000); // [RL9]
            op_set_pwm <= (word[15:14] == 2'b01) & (word[13:8] == 6'h00); // [RL9]
            op_ramp_wait <= ~word[15] & (word != 16'h0000) &
               ~((word[15:14] == 2'b01) & (word[13:8] == 6'h00)); // [RL9]
            op_branch <= (word[15:13] == 3'b101); // [RL21]
            op_end <= (word[15:13] == 3'b110); // [RL21]
            op_trigger <= (word[15:13] == 3'b111); // [RL10]
            ramp_prescale <= word[14]; // [RL9]
            ramp_step_time <= word[13:8];
            ramp_sign <= word[7];
            ramp_increment <= word[6:0];
            set_pwm_value <= word[7:0];
            branch_loop_count <= word[12:7]; // [RL21]
            branch_target_step <= word[3:0];
            end_int <= word[12]; // [RL21]
            end_reset <= word[11];
         end
      end
   end

   // ****************************************
   // triggers
   // ****************************************
   wire trig_dec = dec_req & (dec_engine != 2'b00) & (word[15:13] == 3'b111);
   wire trig_met = (wait_mask_r != 6'h00) & ((pend_r & wait_mask_r) == wait_mask_r);

   always @* begin
      pend_nxt = pend_r;
      if (trig_met) begin
         pend_nxt = pend_r & ~wait_mask_r;
      end
      // an arrival in the clearing cycle is kept
      pend_nxt = pend_nxt | trig_in;
   end

   always @(posedge clk) begin
      if (!rstn) begin
         wait_mask_r <= 6'h00;
         pend_r <= 6'h00;
         trig_out <= 6'h00;
         trig_stall <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         trig_out <= trig_dec ? word[6:1] : 6'h00; // [RL11]
         if (trig_dec) begin
            wait_mask_r <= word[12:7]; // [RL10]
            trig_stall <= (word[12:7] != 6'h00);
         end else if (trig_met) begin
            wait_mask_r <= 6'h00; // [RL10]
            trig_stall <= 1'b0;
         end
      end
   end
endmodule

// ==== shared/led_ctrl_defs.vh ====
`ifndef LED_CTRL_DEFS_VH
`define LED_CTRL_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define OFS_BLUE_PWM 8'h02
`define OFS_GREEN_PWM 8'h03
`define OFS_RED_PWM 8'h04
`define OFS_BLUE_DRIVE 8'h05
`define OFS_GREEN_DRIVE 8'h06
`define OFS_RED_DRIVE 8'h07
`define OFS_CONFIG 8'h08
`define OFS_SOFT_RESET 8'h0d
`define OFS_WHITE_PWM 8'h0e
`define OFS_WHITE_DRIVE 8'h0f
`define OFS_MEM_FIRST 8'h10
`define OFS_MEM_LAST 8'h6f
`define OFS_SOURCE_MAP 8'h70
// ****************************************
// reset values and keys
// ****************************************
`define RST_DRIVE 8'haf
`define RST_CONFIG 8'h00
`define RST_SOURCE_MAP 8'h39
`define RST_PWM 8'h00
`define RST_MEM 8'h00
`define SOFT_RESET_KEY 8'hff
// ****************************************
// field positions
// ****************************************
`define CFG_PWM_FREQ_BIT 6
`define CFG_PWR_SAVE_BIT 5
`define CFG_CLK_DET_BIT 1
`define CFG_INT_CLK_BIT 0
`define MAP_WHITE_HI 7
`define MAP_WHITE_LO 6
`define MAP_RED_HI 5
`define MAP_RED_LO 4
`define MAP_GREEN_HI 3
`define MAP_GREEN_LO 2
`define MAP_BLUE_HI 1
`define MAP_BLUE_LO 0
// ****************************************
// program memory layout
// ****************************************
`define MEM_BYTES 96
`define ENG_SECTION_BYTES 32
`endif

// ==== sim/i2c_host_model.sv ====
`timescale 1ns/1ps
module i2c_host_model (
   // clock shared with the device
   input wire clk,
   // bus lines
   output reg scl = 1'b1,
   output reg sda_low = 1'b0,
   input wire sda
);
   reg nack_r = 1'b0;
   // slow quarter bit so the device's two-flop samplers keep up
   task q;
      begin
         repeat (6) @(posedge clk);
      end
   endtask
   task put_bit(input b);
      begin
         sda_low <= !b;
         q;
         scl <= 1'b1;
         q;
         q;
         scl <= 1'b0;
         q;
      end
   endtask
   task get_bit(output b);
      begin
         sda_low <= 1'b0;
         q;
         scl <= 1'b1;
         q;
         b = sda;
         q;
         scl <= 1'b0;
         q;
      end
   endtask
   task start;
      begin
         sda_low <= 1'b0;
         q;
         scl <= 1'b1;
         q;
         sda_low <= 1'b1;
         q;
         scl <= 1'b0;
         q;
      end
   endtask
   task stop;
      begin
         sda_low <= 1'b1;
         q;
         scl <= 1'b1;
         q;
         sda_low <= 1'b0;
         q;
      end
   endtask
   task put_byte(input [7:0] d);
      integer i;
      reg a;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            put_bit(d[i]);
         end
         get_bit(a);
         nack_r = nack_r | a;
      end
   endtask
   // configuration write after power-up
   task wr(input [6:0] dev, input [7:0] a, input [7:0] d);
      begin
         nack_r = 1'b0;
         start;
         put_byte({dev, 1'b0});
         put_byte(a);
         put_byte(d);
         stop;
      end
   endtask
   task rd(input [6:0] dev, input [7:0] a, output [7:0] d);
      integer i;
      reg b;
      begin
         nack_r = 1'b0;
         start;
         put_byte({dev, 1'b0});
         put_byte(a);
         start;
         put_byte({dev, 1'b1});
         for (i = 7; i >= 0; i = i - 1) begin
            get_bit(b);
            d[i] = b;
         end
         put_bit(1'b1);
         stop;
      end
   endtask
endmodule

// ==== sim/led_ctrl_monitor.sv ====
`timescale 1ns/1ps
module led_ctrl_monitor (
   // clock and reset
   input wire clk,
   input wire rstn,
   // bus pin
   input wire sda_out,
   // outputs under watch
   input wire [7:0] white_drive,
   input wire clock_use_external,
   input wire clock_use_internal,
   input wire clock_auto_detect,
   // decode port
   input wire dec_req,
   input wire [1:0] dec_engine,
   input wire dec_valid,
   input wire op_goto_start,
   input wire op_set_pwm,
   input wire op_ramp_wait,
   input wire op_branch,
   input wire op_end,
   input wire op_trigger,
   input wire ramp_prescale,
   input wire [5:0] ramp_step_time,
   input wire [7:0] set_pwm_value,
   // triggers
   input wire [5:0] trig_out,
   input wire trig_stall
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire take = dec_req && dec_engine != 2'd0;
   wire [5:0] ops = {op_goto_start, op_set_pwm, op_ramp_wait, op_branch, op_end, op_trigger};
   a_decode_answer: assert property (take |=> dec_valid)
      else $error("decode request not answered");
   a_decode_refused: assert property (!take |=> !dec_valid)
      else $error("decode valid without request");
   a_one_class: assert property (dec_valid |-> $onehot0(ops))
      else $error("more than one instruction class");
   a_goto_fields: assert property (dec_valid && op_goto_start |-> set_pwm_value == 8'h00
      && ramp_step_time == 6'h00 && !ramp_prescale)
      else $error("goto start with nonzero word");
   a_set_pwm_fields: assert property (dec_valid && op_set_pwm |-> ramp_prescale
      && ramp_step_time == 6'h00)
      else $error("set pwm class with wrong top bits");
   a_trig_source: assert property (trig_out != 6'h00 |-> dec_valid && op_trigger)
      else $error("trigger sent outside a trigger decode");
   a_stall_source: assert property ($rose(trig_stall) |-> dec_valid && op_trigger)
      else $error("stall raised outside a trigger decode");
   a_clock_one_source: assert property ($onehot({clock_use_external,
      clock_use_internal, clock_auto_detect}))
      else $error("clock source not unique");
   a_sda_open_drain: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_reset_drive: assert property (disable iff (1'b0) !rstn |=> white_drive == 8'haf
      && clock_use_external)
      else $error("reset values wrong");
   c_trigger: cover property (dec_valid && op_trigger && trig_stall);
   c_stall_end: cover property ($fell(trig_stall));
   c_branch: cover property (dec_valid && op_branch);
endmodule
bind led_channel_source_map_and_engine_instr led_ctrl_monitor mon (.*);

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`include "led_ctrl_defs.vh"
module tb_top;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg pin0 = 1'b0, pin1 = 1'b0, dec_req = 1'b0;
   reg [1:0] dec_engine = 2'd0;
   reg [3:0] dec_step = 4'h0;
   reg [5:0] trig_in = 6'h00;
   reg [7:0] e1 = 8'h11, e2 = 8'h22, e3 = 8'h33, rv;
   reg [6:0] dev = {5'b0110_0, 2'b00};
   integer failures = 0, compares = 0, i;
   wire scl, sda, sda_low, sda_out, sda_oe_n, pfs, pse, cue, cui, cad, dv;
   wire o_go, o_set, o_rmp, o_br, o_end, o_trg, rp, rs, ei, er, stall;
   wire [7:0] wp, rp_, gp, bp, wd, rd_, gd, bd, spv;
   wire [5:0] rst_t, blc, tout;
   wire [6:0] rinc;
   wire [3:0] bts;
   assign sda = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
   always #12.5 clk = ~clk;
   i2c_host_model host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
   led_channel_source_map_and_engine_instr dut (.clk(clk), .rstn(rstn), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_addr_pin0(pin0),
      .bus_addr_pin1(pin1), .eng1_pwm(e1), .eng2_pwm(e2), .eng3_pwm(e3), .white_pwm(wp),
      .red_pwm(rp_), .green_pwm(gp), .blue_pwm(bp), .white_drive(wd), .red_drive(rd_),
      .green_drive(gd), .blue_drive(bd), .pwm_freq_select(pfs), .power_save_enable(pse),
      .clock_use_external(cue), .clock_use_internal(cui), .clock_auto_detect(cad),
      .dec_req(dec_req), .dec_engine(dec_engine), .dec_step(dec_step), .dec_valid(dv),
      .op_goto_start(o_go), .op_set_pwm(o_set), .op_ramp_wait(o_rmp), .op_branch(o_br),
      .op_end(o_end), .op_trigger(o_trg), .ramp_prescale(rp), .ramp_step_time(rst_t),
      .ramp_sign(rs), .ramp_increment(rinc), .set_pwm_value(spv), .branch_loop_count(blc),
      .branch_target_step(bts), .end_int(ei), .end_reset(er), .trig_in(trig_in),
      .trig_out(tout), .trig_stall(stall));
   // ****************************************
   // shared tasks
   // ****************************************
   task chk(input [8*8-1:0] what, input [15:0] seen, input [15:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   function [7:0] pick(input [1:0] c, input [7:0] d);
      pick = (c == 2'd0) ? d : (c == 2'd1) ? e1 : (c == 2'd2) ? e2 : e3;
   endfunction
   task dreq(input [1:0] e, input [3:0] s, input [15:0] w);
      reg [5:0] ops;
      begin
         ops = (w == 16'h0000) ? 6'b10_0000 : (w[15:14] == 2'b01 && w[13:8] == 6'h00)
            ? 6'b01_0000 : !w[15] ? 6'b00_1000 : (w[15:13] == 3'b101) ? 6'b00_0100
            : (w[15:13] == 3'b110) ? 6'b00_0010 : 6'b00_0001;
         @(posedge clk);
         dec_req <= 1'b1;
         dec_engine <= e;
         dec_step <= s;
         @(posedge clk);
         dec_req <= 1'b0;
         #1;
         chk("valid", dv, 1'b1);
         chk("ops", {o_go, o_set, o_rmp, o_br, o_end, o_trg}, ops);
         chk("ramp", {rp, rst_t, rs, rinc}, w[14:0]);
         chk("pwmval", spv, w[7:0]);
         chk("branch", {blc, bts}, {w[12:7], w[3:0]});
         chk("end", {ei, er}, w[12:11]);
         chk("trigout", tout, ops[0] ? w[6:1] : 6'h00);
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_reset;
      begin
         chk("drives", {wd, rd_}, 16'hafaf);
         chk("drives", {gd, bd}, 16'hafaf);
         chk("pwms", {wp, rp_}, {8'h00, e3});
         chk("pwms", {gp, bp}, {e2, e1});
         chk("config", {pfs, pse, cue, cui, cad}, 5'b0_0100);
         host.rd(dev, `OFS_WHITE_DRIVE, rv);
         chk("rd_white", rv, `RST_DRIVE);
         host.rd(dev, `OFS_SOURCE_MAP, rv);
         chk("rd_map", rv, `RST_SOURCE_MAP);
         host.rd(dev, `OFS_MEM_LAST, rv);
         chk("rd_mem", rv, `RST_MEM);
      end
   endtask
   task t_map;
      reg [7:0] m [0:5];
      begin
         m[0] = 8'h00; m[1] = 8'h55; m[2] = 8'haa; m[3] = 8'hff; m[4] = 8'h1b; m[5] = 8'he4;
         host.wr(dev, `OFS_WHITE_PWM, 8'ha1);
         host.wr(dev, `OFS_RED_PWM, 8'ha2);
         host.wr(dev, `OFS_GREEN_PWM, 8'ha3);
         host.wr(dev, `OFS_BLUE_PWM, 8'ha4);
         for (i = 0; i < 6; i = i + 1) begin
            host.wr(dev, `OFS_SOURCE_MAP, m[i]);
            chk("white", wp, pick(m[i][7:6], 8'ha1));
            chk("red", rp_, pick(m[i][5:4], 8'ha2));
            chk("green", gp, pick(m[i][3:2], 8'ha3));
            chk("blue", bp, pick(m[i][1:0], 8'ha4));
         end
      end
   endtask
   task t_drive;
      begin
         host.wr(dev, `OFS_BLUE_DRIVE, 8'hdc);
         host.wr(dev, `OFS_GREEN_DRIVE, 8'hc8);
         host.wr(dev, `OFS_RED_DRIVE, 8'hf0);
         host.wr(dev, `OFS_WHITE_DRIVE, 8'hff);
         chk("drives", {bd, gd}, 16'hdcc8);
         chk("drives", {rd_, wd}, 16'hf0ff);
         host.rd(dev, `OFS_WHITE_DRIVE, rv);
         chk("rd_white", rv, 8'hff);
         host.wr(dev, `OFS_SOFT_RESET, `SOFT_RESET_KEY);
         chk("softrst", wd, `RST_DRIVE);
      end
   endtask
   task t_config;
      reg [7:0] v [0:3];
      reg [4:0] x [0:3];
      begin
         v[0] = 8'h61; v[1] = 8'h02; v[2] = 8'h43; v[3] = 8'h20;
         x[0] = 5'b1_1010; x[1] = 5'b0_0001; x[2] = 5'b1_0010; x[3] = 5'b0_1100;
         for (i = 0; i < 4; i = i + 1) begin
            host.wr(dev, `OFS_CONFIG, v[i]);
            chk("config", {pfs, pse, cue, cui, cad}, x[i]);
         end
      end
   endtask
   task t_addr;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            {pin1, pin0} <= i[1:0];
            dev = {5'b0110_0, i[1:0]};
            host.wr({5'b0110_0, ~i[1:0]}, `OFS_SOURCE_MAP, 8'h00);
            chk("nack", host.nack_r, 1'b1);
            host.wr(dev, `OFS_SOURCE_MAP, 8'h39);
            chk("ack", host.nack_r, 1'b0);
         end
      end
   endtask
   task t_decode;
      reg [15:0] w [0:5];
      begin
         w[0] = 16'h40ff; w[1] = 16'h4d00; w[2] = 16'h0000;
         w[3] = 16'ha290; w[4] = 16'hd800; w[5] = 16'h1234;
         for (i = 0; i < 5; i = i + 1) begin
            host.wr(dev, 8'h10 + 2 * i, w[i][15:8]);
            host.wr(dev, 8'h11 + 2 * i, w[i][7:0]);
         end
         host.wr(dev, 8'h30, w[5][15:8]);
         host.wr(dev, 8'h31, w[5][7:0]);
         host.wr(dev, 8'h6e, 8'he2);
         host.wr(dev, 8'h6f, 8'hd4);
         for (i = 0; i < 5; i = i + 1) dreq(2'd1, i[3:0], w[i]);
         dreq(2'd2, 4'h0, w[5]);
         @(posedge clk);
         dec_req <= 1'b1;
         dec_engine <= 2'd0;
         @(posedge clk);
         dec_req <= 1'b0;
         #1;
         chk("refused", dv, 1'b0);
         dreq(2'd3, 4'hf, 16'he2d4);
         chk("stall", stall, 1'b1);
         @(posedge clk);
         trig_in <= 6'h03;
         @(posedge clk);
         trig_in <= 6'h00;
         repeat (2) @(posedge clk);
         #1;
         chk("stall", stall, 1'b1);
         @(posedge clk);
         trig_in <= 6'h04;
         @(posedge clk);
         trig_in <= 6'h00;
         @(posedge clk);
         #1;
         chk("stall", stall, 1'b0);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_map;
      t_drive;
      t_config;
      t_addr;
      t_decode;
      tally_and_finish;
   end
   initial begin
      repeat (90000) @(posedge clk);
      failures = failures + 1;
      tally_and_finish;
   end
endmodule
